/* inc/irs_pkg.sv */
package irs_pkg;

  // Master clock period in picoseconds (40 MHz).
  localparam int unsigned CLK_PERIOD_PS = 25000;

  localparam int unsigned ADDR_W = 7;
  localparam logic [ADDR_W-1:0] LAST_ROW = 7'h7f;
  localparam logic [ADDR_W-1:0] LAST_COL = 7'h7f;
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 7'h00;

  // Four master clock cycles per pixel: two for the signal level, two reset.
  localparam logic [1:0] PIX_LAST_PHASE = 2'h3;
  localparam logic [1:0] PIX_RST_PHASE = 2'h2;

  // Row timing, in nanoseconds as specified.
  localparam int unsigned XFER_NS = 1000;
  localparam int unsigned RSTH_NS = 1000;
  localparam int unsigned ROW_BLANK_NS = 4600;
  localparam int unsigned END_BLANK_NS = 300;

  // Least times, rounded up to whole cycles.
  localparam logic [7:0] XFER_CYC =
    8'((XFER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RSTH_CYC =
    8'((RSTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] ROW_BLANK_CYC =
    8'((ROW_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] END_BLANK_CYC =
    8'((END_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] GAP_CYC = ROW_BLANK_CYC - XFER_CYC - RSTH_CYC;
  localparam logic [7:0] TMR_ONE = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_RSTH,
    ST_SHIFT,
    ST_GAP,
    ST_DONE
  } irs_state_e_t;

  typedef struct packed {
    logic [ADDR_W-1:0] row_sel;
    logic [ADDR_W-1:0] col_sel;
    logic              row_active;
    logic              sig_xfer;
    logic              row_reset;
    logic              all_reset;
    logic              sh_closed;
    logic              video_sig;
    logic              video_rst;
    logic              strobe;
    logic              frame_busy;
  } irs_ctrl_t;

  localparam irs_ctrl_t CTRL_RST = '{
    row_sel: 7'h00, col_sel: 7'h00, row_active: 1'b0, sig_xfer: 1'b0,
    row_reset: 1'b0, all_reset: 1'b1, sh_closed: 1'b1, video_sig: 1'b0,
    video_rst: 1'b0, strobe: 1'b0, frame_busy: 1'b0};

  typedef struct packed {
    irs_state_e_t      st;
    logic [1:0]        phase;
    logic [7:0]        tmr;
    logic              global_mode;
    logic              fsp_s1;
    logic              fsp_s2;
    logic              fsp_d;
    logic              m1_s1;
    logic              m1_s2;
    logic              m2_s1;
    logic              m2_s2;
    irs_ctrl_t         out;
  } irs_reg_t;

  localparam irs_reg_t REG_RST = '{
    st: ST_IDLE, phase: 2'h0, tmr: 8'h00, global_mode: 1'b0,
    fsp_s1: 1'b0, fsp_s2: 1'b0, fsp_d: 1'b0, m1_s1: 1'b0, m1_s2: 1'b0,
    m2_s1: 1'b0, m2_s2: 1'b0, out: CTRL_RST};

endpackage

/* logic/irs_sequencer.sv */
// Operation
// - Rows selected singly, top to bottom, 128.
// - Rolling: transfer signal level, then hold it.
// - Then reset row pixels, hold reset level.
// - Scan columns, output signal and reset levels.
// - Rolling: pixel sample-hold switches always closed.
// - Row done: release row reset, advance row.
// - Frame pulse rises; next scan then starts.
// - Rolling integration spans one row to next frame.
// - Global: integration equals frame pulse low time.
// - Global: hold all pixels together, read rows.
// - Global: held pixel level becomes row signal.
// - Global: pulse fall after last row releases resets.
// - Four clock cycles per pixel on video.
// - Scan runs only while frame pulse high.
`timescale 1ns/1ps

module irs_sequencer (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     frame_start_pulse,
  input  wire logic                     mode_sel_1,
  input  wire logic                     mode_sel_2,
  output      logic                     conversion_sample_strobe,
  output      irs_pkg::irs_ctrl_t       pixel_readout_ctrl
);
  import irs_pkg::*;

  irs_reg_t r_reg;
  irs_reg_t r_next;
  logic     fsp_rise;
  logic     fsp_fall;
  logic     global_req;

  assign fsp_rise = r_reg.fsp_s2 & ~r_reg.fsp_d;
  assign fsp_fall = ~r_reg.fsp_s2 & r_reg.fsp_d;
  assign global_req = r_reg.m1_s2 & ~r_reg.m2_s2;

  always_comb begin
    r_next = r_reg;
    r_next.fsp_s1 = frame_start_pulse;
    r_next.fsp_s2 = r_reg.fsp_s1;
    r_next.fsp_d = r_reg.fsp_s2;
    r_next.m1_s1 = mode_sel_1;
    r_next.m1_s2 = r_reg.m1_s1;
    r_next.m2_s1 = mode_sel_2;
    r_next.m2_s2 = r_reg.m2_s1;
    r_next.out.video_sig = 1'b0;
    r_next.out.video_rst = 1'b0;
    r_next.out.strobe = 1'b0;
    r_next.tmr = r_reg.tmr - TMR_ONE;

    case (r_reg.st)
      ST_IDLE: begin
        r_next.out.sh_closed = 1'b1;
        if (fsp_rise) begin
          r_next.global_mode = global_req;
          r_next.st = ST_XFER;
          r_next.tmr = XFER_CYC;
          r_next.out.frame_busy = 1'b1;
          r_next.out.row_active = 1'b1;
          r_next.out.sig_xfer = 1'b1;
          r_next.out.row_sel = FIRST_ADDR;
          r_next.out.col_sel = FIRST_ADDR;
          // Global opens every pixel hold at once.
          r_next.out.sh_closed = ~global_req;
        end
      end

      ST_XFER: begin
        // In global mode the held pixel level is moved.
        if (r_reg.tmr == TMR_ONE) begin
          r_next.out.sig_xfer = 1'b0;
          r_next.out.row_reset = 1'b1;
          r_next.st = ST_RSTH;
          r_next.tmr = RSTH_CYC;
        end
      end

      ST_RSTH: begin
        if (r_reg.tmr == TMR_ONE) begin
          r_next.st = ST_SHIFT;
          r_next.phase = 2'h0;
          r_next.out.col_sel = FIRST_ADDR;
        end
      end

      ST_SHIFT: begin
        // Column scan, signal then reset level.
        r_next.out.video_sig = (r_reg.phase < PIX_RST_PHASE);
        r_next.out.video_rst = (r_reg.phase >= PIX_RST_PHASE);
        r_next.out.strobe = r_reg.phase[0];
        r_next.phase = r_reg.phase + 2'h1;
        if (r_reg.phase == PIX_LAST_PHASE) begin
          r_next.out.col_sel = r_reg.out.col_sel + 7'h01;
          if (r_reg.out.col_sel == LAST_COL) begin
            // Release row reset and advance together.
            r_next.out.row_reset = 1'b0;
            r_next.out.col_sel = FIRST_ADDR;
            r_next.st = ST_GAP;
            if (r_reg.out.row_sel == LAST_ROW) begin
              r_next.out.row_active = 1'b0;
              r_next.tmr = END_BLANK_CYC;
            end else begin
              r_next.out.row_sel = r_reg.out.row_sel + 7'h01;
              r_next.tmr = GAP_CYC;
            end
          end
        end
      end

      ST_GAP: begin
        if (r_reg.tmr == TMR_ONE) begin
          if (r_reg.out.row_active) begin
            r_next.st = ST_XFER;
            r_next.tmr = XFER_CYC;
            r_next.out.sig_xfer = 1'b1;
          end else begin
            r_next.st = ST_DONE;
            r_next.out.frame_busy = 1'b0;
            r_next.out.all_reset = 1'b1;
          end
        end
      end

      ST_DONE: begin
        // Pulse fall releases all resets together.
        // Integration runs while the pulse is low.
        if (fsp_fall) begin
          r_next.out.all_reset = 1'b0;
          r_next.out.sh_closed = 1'b1;
          r_next.st = ST_IDLE;
        end
      end

      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    // A pulse drop mid-scan ends the frame.
    if ((r_reg.st != ST_IDLE) && (r_reg.st != ST_DONE) && !r_reg.fsp_s2) begin
      r_next.st = ST_IDLE;
      r_next.out.frame_busy = 1'b0;
      r_next.out.row_active = 1'b0;
      r_next.out.sig_xfer = 1'b0;
      r_next.out.row_reset = 1'b0;
      r_next.out.all_reset = 1'b0;
      r_next.out.sh_closed = 1'b1;
      r_next.out.video_sig = 1'b0;
      r_next.out.video_rst = 1'b0;
      r_next.out.strobe = 1'b0;
    end
  end

  // Everything freezes with the clock enable, so timing scales with it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= REG_RST;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign pixel_readout_ctrl = r_reg.out;
  assign conversion_sample_strobe = r_reg.out.strobe;

endmodule

/* verif/irs_ctl_model.sv */
`timescale 1ns/1ps
module irs_ctl_model (
  input  wire logic core_clk,
  input  wire logic go,
  input  wire logic glob,
  output logic      frame_start_pulse,
  output logic      mode_sel_1,
  output logic      mode_sel_2
);
  int low_n = 0;
  initial frame_start_pulse = 1'b0;
  assign mode_sel_1 = glob;
  assign mode_sel_2 = 1'b0;
  always @(negedge core_clk) begin
    low_n <= frame_start_pulse ? 0 : low_n + 1;
    frame_start_pulse <= go && (frame_start_pulse || low_n >= 20);
  end
endmodule

/* verif/irs_sequencer_checker.sv */
`timescale 1ns/1ps
module irs_sequencer_checker (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              frame_start_pulse,
  input wire logic              mode_sel_1,
  input wire logic              mode_sel_2,
  input wire logic              conversion_sample_strobe,
  input wire irs_pkg::irs_ctrl_t pixel_readout_ctrl
);
  import irs_pkg::*;
  irs_ctrl_t c;
  assign c = pixel_readout_ctrl;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  sequence s_sig; c.video_sig && !c.video_rst; endsequence
  sequence s_rst; c.video_rst && !c.video_sig; endsequence
  property p_pix;
    $rose(c.video_sig) |-> s_sig ##1 s_sig ##1 s_rst ##1 s_rst;
  endproperty
  // One strobe per level, so it never stands two cycles in a row.
  property p_strb;
    conversion_sample_strobe |-> (c.video_sig || c.video_rst)
      ##1 !conversion_sample_strobe;
  endproperty
  property p_col;
    c.row_active && $past(c.row_active) && $changed(c.col_sel)
      |-> c.col_sel == 7'($past(c.col_sel) + 7'h01);
  endproperty
  property p_row;
    c.frame_busy && $past(c.frame_busy) && $changed(c.row_sel)
      |-> c.row_sel == 7'($past(c.row_sel) + 7'h01);
  endproperty
  property p_rel;
    $fell(c.row_reset) && c.frame_busy && $past(c.row_sel) != LAST_ROW
      |-> c.row_sel == 7'($past(c.row_sel) + 7'h01);
  endproperty
  property p_xfr;
    $fell(c.sig_xfer) && c.frame_busy |-> c.row_reset && !c.video_sig;
  endproperty
  property p_sh;
    $rose(c.frame_busy) |-> c.sh_closed == !(mode_sel_1 && !mode_sel_2);
  endproperty
  property p_abt; !frame_start_pulse [*4] |-> !c.frame_busy; endproperty
  a_pix: assert property (p_pix) else $error("pixel phases");
  a_strb: assert property (p_strb) else $error("strobe");
  a_col: assert property (p_col) else $error("column step");
  a_row: assert property (p_row) else $error("row step");
  a_rel: assert property (p_rel) else $error("row release");
  a_xfr: assert property (p_xfr) else $error("transfer order");
  a_sh: assert property (p_sh) else $error("hold switch");
  a_abt: assert property (p_abt) else $error("scan while low");
endmodule
bind irs_sequencer irs_sequencer_checker chk_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .frame_start_pulse(frame_start_pulse),
  .mode_sel_1(mode_sel_1), .mode_sel_2(mode_sel_2),
  .conversion_sample_strobe(conversion_sample_strobe),
  .pixel_readout_ctrl(pixel_readout_ctrl));

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import irs_pkg::*;
  logic      core_clk = 1'b0;
  logic      sys_rst = 1'b1;
  logic      go = 1'b0;
  logic      glob = 1'b0;
  logic      fsp, m1, m2, strobe;
  irs_ctrl_t c;
  int        fail_count = 0;
  int        samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  irs_ctl_model ctl (.core_clk(core_clk), .go(go), .glob(glob),
    .frame_start_pulse(fsp), .mode_sel_1(m1), .mode_sel_2(m2));
  irs_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .frame_start_pulse(fsp), .mode_sel_1(m1), .mode_sel_2(m2),
    .conversion_sample_strobe(strobe), .pixel_readout_ctrl(c));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (c.frame_busy !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > lim) chk(c.frame_busy, lvl);
      if (n > lim) wrap_up();
    end
  endtask
  task automatic t_rolling;
    int n, steps, strobes, opened;
    logic [6:0] prev;
    {n, steps, strobes, opened} = '0;
    go = 1'b1;
    wait_busy(1'b1, 20);
    chk(c.row_sel, 0);
    prev = c.row_sel;
    while (c.frame_busy === 1'b1 && n < 90000) begin
      if (c.row_sel !== prev) steps++;
      prev = c.row_sel;
      if (strobe === 1'b1) strobes++;
      if (c.sh_closed !== 1'b1) opened++;
      @(negedge core_clk);
      n++;
    end
    chk(c.frame_busy, 0);
    chk(steps, 127);
    chk(prev, LAST_ROW);
    chk(strobes, 32768);
    chk(opened, 0);
    go = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(c.all_reset, 0);
  endtask
  task automatic t_global;
    glob = 1'b1;
    repeat (30) @(negedge core_clk);
    go = 1'b1;
    wait_busy(1'b1, 20);
    chk(c.sh_closed, 0);
    repeat (39) @(negedge core_clk);
    chk(c.sig_xfer, 1);
    @(negedge core_clk);
    chk({c.sig_xfer, c.row_reset}, 1);
    repeat (660) @(negedge core_clk);
    chk(c.row_sel, 1);
    go = 1'b0;
    wait_busy(1'b0, 5);
    chk(c.sig_xfer, 0);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    chk({c.all_reset, c.sh_closed, c.frame_busy}, 6);
    t_rolling();
    t_global();
    wrap_up();
  end
endmodule
